// >>> src/motion_wake_controller.sv
// Purpose: wake-on-motion control with APB registers and host alert pin
// Assumes: standard APB master; inputs synchronous to clock
// Notes: staged settings take effect only at a restart request
//
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/1ps
module motion_wake_controller #(
    parameter int AXES = 3,
    parameter int ACCEL_W = 16,
    parameter int ALERT_WIDTH = motion_wake_pkg::ALERT_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // inertial sensor samples
    input wire logic [AXES*ACCEL_W-1:0] accel,
    // outputs
    output logic motionAlertOutput,
    output logic receiverAsleep,
    output logic irq
);

    localparam int CNT_W = $clog2(ALERT_WIDTH + 1);

    typedef struct packed {
        motion_wake_pkg::rx_state_t rx;                         // receiver power state
        logic [motion_wake_pkg::MODE_W-1:0] mode;               // staged mode
        logic [motion_wake_pkg::THLD_W-1:0] thld;               // staged threshold
        logic [motion_wake_pkg::MODE_W-1:0] appliedMode;        // mode in force
        logic [motion_wake_pkg::THLD_W-1:0] appliedThld;        // threshold in force
        logic wakeSrc;                                          // interrupt zero wake enabled
        logic [motion_wake_pkg::INT_W-1:0] intStatus;           // sticky events
        logic [motion_wake_pkg::INT_W-1:0] intMask;             // event enables
        logic [CNT_W-1:0] alertCount;                           // alert cycles left
        logic linePrev;                                         // last motion line
        logic alert;                                            // alert pin
        logic irq;                                              // interrupt pin
        logic pready;                                           // apb ready
        logic pslverr;                                          // apb error
        logic [31:0] prdata;                                    // apb read data
    } ctrl_state_t;

    ctrl_state_t st;
    ctrl_state_t next_st;
    logic motionLine;     // sensor interrupt line
    logic motionEvent;    // rising edge of the line
    logic alertEnable;    // mode drives the pin
    logic wakeEnable;     // mode wakes the receiver
    logic apbAccess;      // access phase completing
    logic apbWrite;       // completing write
    logic mapped;         // address decodes
    logic [31:0] readWord; // read mux result
    logic [motion_wake_pkg::INT_W-1:0] events;  // this cycle's events

    // sensor threshold check on applied threshold
    motion_threshold_detector #(
        .AXES(AXES),
        .ACCEL_W(ACCEL_W)
    ) u_detector (
        .clock(clock),
        .rst(rst),
        .thresholdCode(st.appliedThld),
        .accel(accel),
        .motionLine(motionLine)
    );

    // mode decode from the applied setting
    always_comb
    begin
        case (st.appliedMode)
            motion_wake_pkg::MODE_OFF:
            begin
                alertEnable = 1'b0;
                wakeEnable = 1'b0;
            end
            motion_wake_pkg::MODE_HOST:
            begin
                alertEnable = 1'b1;
                wakeEnable = 1'b0;
            end
            motion_wake_pkg::MODE_WAKE:
            begin
                alertEnable = 1'b0;
                wakeEnable = 1'b1;
            end
            motion_wake_pkg::MODE_BOTH:
            begin
                alertEnable = 1'b1;
                wakeEnable = 1'b1;
            end
            default:
            begin
                alertEnable = 1'b0;
                wakeEnable = 1'b0;
            end
        endcase
    end

    // rising edge of the sensor interrupt is one motion event in any mode but off
    assign motionEvent = motionLine && !st.linePrev && (alertEnable || wakeEnable);

    // apb decode: completes when ready is already high
    assign apbAccess = psel && penable && st.pready;
    assign apbWrite = apbAccess && pwrite;

    // read mux and address decode
    always_comb
    begin
        mapped = 1'b1;
        readWord = '0;
        case (paddr)
            motion_wake_pkg::CONFIG_OFFSET:
            begin
                readWord[motion_wake_pkg::MODE_LSB +: motion_wake_pkg::MODE_W] = st.mode;
                readWord[motion_wake_pkg::THLD_LSB +: motion_wake_pkg::THLD_W] = st.thld;
            end
            motion_wake_pkg::APPLIED_OFFSET:
            begin
                readWord[motion_wake_pkg::MODE_LSB +: motion_wake_pkg::MODE_W] =
                    st.appliedMode;
                readWord[motion_wake_pkg::THLD_LSB +: motion_wake_pkg::THLD_W] =
                    st.appliedThld;
            end
            motion_wake_pkg::POWER_REQ_OFFSET:
            begin
                readWord[motion_wake_pkg::WAKE_SRC_BIT] = st.wakeSrc;
            end
            motion_wake_pkg::STATE_OFFSET:
            begin
                readWord[motion_wake_pkg::STATE_ASLEEP_BIT] = (st.rx == motion_wake_pkg::RX_ASLEEP);
                readWord[motion_wake_pkg::STATE_LINE_BIT] = motionLine;
                readWord[motion_wake_pkg::STATE_WAKE_SRC_BIT] = st.wakeSrc;
            end
            motion_wake_pkg::INT_STATUS_OFFSET:
            begin
                readWord[motion_wake_pkg::INT_W-1:0] = st.intStatus;
            end
            motion_wake_pkg::INT_MASK_OFFSET:
            begin
                readWord[motion_wake_pkg::INT_W-1:0] = st.intMask;
            end
            motion_wake_pkg::RESTART_OFFSET:
            begin
                readWord = '0;  // write-only command
            end
            default:
            begin
                mapped = 1'b0;  // unmapped reads zero with error
            end
        endcase
    end

    // next-state logic for the whole controller
    always_comb
    begin
        next_st = st;
        events = '0;
        next_st.linePrev = motionLine;

        // apb handshake: one wait state, then ready for a cycle
        next_st.pready = psel && penable && !st.pready;
        next_st.pslverr = psel && penable && !st.pready && !mapped;
        if (psel && penable && !st.pready)
        begin
            next_st.prdata = pwrite ? 32'h0000_0000 : readWord;
        end

        // register writes
        if (apbWrite && paddr == motion_wake_pkg::CONFIG_OFFSET)
        begin
            next_st.mode = pwdata[motion_wake_pkg::MODE_LSB +: motion_wake_pkg::MODE_W];
            next_st.thld = pwdata[motion_wake_pkg::THLD_LSB +: motion_wake_pkg::THLD_W];
        end
        if (apbWrite && paddr == motion_wake_pkg::INT_MASK_OFFSET)
        begin
            next_st.intMask = pwdata[motion_wake_pkg::INT_W-1:0];
        end
        // staged settings reach the sensor only at a power cycle
        if (apbWrite && paddr == motion_wake_pkg::RESTART_OFFSET
            && pwdata[motion_wake_pkg::RESTART_BIT])
        begin
            next_st.appliedMode = st.mode;
            next_st.appliedThld = st.thld;
            next_st.rx = motion_wake_pkg::RX_AWAKE;
        end

        // power request: only duration zero enters backup sleep
        if (apbWrite && paddr == motion_wake_pkg::POWER_REQ_OFFSET
            && pwdata[motion_wake_pkg::REQ_GO_BIT])
        begin
            next_st.wakeSrc = pwdata[motion_wake_pkg::WAKE_SRC_BIT];
            if (pwdata[motion_wake_pkg::DURATION_LSB +: motion_wake_pkg::DURATION_W] == '0)
            begin
                next_st.rx = motion_wake_pkg::RX_ASLEEP;
            end
        end

        // receiver power state machine
        case (st.rx)
            motion_wake_pkg::RX_AWAKE:
            begin
                next_st.rx = next_st.rx;  // stays awake unless requested
            end
            motion_wake_pkg::RX_ASLEEP:
            begin
                // wake needs a waking mode and interrupt zero wake left on
                if (motionEvent && wakeEnable && st.wakeSrc)
                begin
                    next_st.rx = motion_wake_pkg::RX_AWAKE;
                    events[motion_wake_pkg::INT_WAKE_BIT] = 1'b1;
                end
            end
            default:
            begin
                next_st.rx = motion_wake_pkg::RX_AWAKE;
            end
        endcase

        // host alert pulse, retriggered per event
        if (motionEvent && alertEnable)
        begin
            next_st.alertCount = CNT_W'(ALERT_WIDTH);
        end
        else if (st.alertCount != '0)
        begin
            next_st.alertCount = st.alertCount - 1'b1;
        end
        next_st.alert = (next_st.alertCount != '0);
        events[motion_wake_pkg::INT_MOTION_BIT] = motionEvent;

        // sticky status: write one clears, a new event wins
        if (apbWrite && paddr == motion_wake_pkg::INT_STATUS_OFFSET)
        begin
            next_st.intStatus = st.intStatus & ~pwdata[motion_wake_pkg::INT_W-1:0];
        end
        next_st.intStatus = next_st.intStatus | events;
        next_st.irq = |(next_st.intStatus & next_st.intMask);
    end

    // single state register; settings reset to zero
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    // outputs straight from state flops
    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign motionAlertOutput = st.alert;
    assign receiverAsleep = (st.rx == motion_wake_pkg::RX_ASLEEP);
    assign irq = st.irq;

endmodule // motion_wake_controller

// >>> src/motion_wake_pkg.sv
// Purpose: shared constants for the motion wake controller
// Assumes: 32-bit APB register bus, one aligned word per register
// Notes: offsets are byte addresses; fields sit in the low bits, except the wake source bit at 16 and the request go bit at 31
package motion_wake_pkg;

    // register byte offsets
    localparam logic [7:0] CONFIG_OFFSET = 8'h00;      // staged mode and threshold
    localparam logic [7:0] APPLIED_OFFSET = 8'h04;     // settings in force
    localparam logic [7:0] POWER_REQ_OFFSET = 8'h08;   // power request message
    localparam logic [7:0] STATE_OFFSET = 8'h0c;       // receiver and line state
    localparam logic [7:0] INT_STATUS_OFFSET = 8'h10;  // sticky events, write one clears
    localparam logic [7:0] INT_MASK_OFFSET = 8'h14;    // event enables
    localparam logic [7:0] RESTART_OFFSET = 8'h18;     // power-cycle request

    // config and applied field layout
    localparam int MODE_LSB = 0;        // motion_wake_mode_setting [1:0]
    localparam int MODE_W = 2;
    localparam int THLD_LSB = 8;        // motion_wake_threshold_setting [15:8]
    localparam int THLD_W = 8;

    // power request field layout
    localparam int DURATION_LSB = 0;    // task duration [15:0]
    localparam int DURATION_W = 16;
    localparam int WAKE_SRC_BIT = 16;   // external_interrupt_zero_source enable
    localparam int REQ_GO_BIT = 31;     // issue the request

    // state register bits
    localparam int STATE_ASLEEP_BIT = 0;
    localparam int STATE_LINE_BIT = 1;
    localparam int STATE_WAKE_SRC_BIT = 2;

    // interrupt status and mask bits
    localparam int INT_MOTION_BIT = 0;  // motion seen
    localparam int INT_WAKE_BIT = 1;    // receiver woken by motion
    localparam int INT_W = 2;

    // restart register bit
    localparam int RESTART_BIT = 0;

    // reset values
    localparam logic [MODE_W-1:0] MODE_RESET = 2'h0;
    localparam logic [THLD_W-1:0] THLD_RESET = 8'h00;

    // mode encodings
    localparam logic [MODE_W-1:0] MODE_OFF = 2'h0;
    localparam logic [MODE_W-1:0] MODE_HOST = 2'h1;
    localparam logic [MODE_W-1:0] MODE_WAKE = 2'h2;
    localparam logic [MODE_W-1:0] MODE_BOTH = 2'h3;

    // threshold scale: acceleration counts in g/254, code 1 is zero
    localparam logic [THLD_W-1:0] THLD_ZERO_CODE = 8'h01;
    localparam logic [THLD_W-1:0] THLD_DEFAULT_LEVEL = 8'h7f;  // half g
    localparam logic [THLD_W-1:0] THRESHOLD_RESERVED_CODE = 8'h00;  // code 0 selects half g

    // alert pulse width in clock cycles
    localparam int ALERT_CYCLES = 16;

    // receiver power state
    typedef enum logic [0:0] {
        RX_AWAKE = 1'b0,
        RX_ASLEEP = 1'b1
    } rx_state_t;

endpackage

// >>> src/motion_threshold_detector.sv
// Purpose: per-axis acceleration threshold check giving the motion line
// Assumes: signed axis samples in units of g/254, synchronous to clock
// Notes: runs regardless of receiver sleep, like the sensor's low-power path
`timescale 1ns/1ps
module motion_threshold_detector #(
    parameter int AXES = 3,
    parameter int ACCEL_W = 16
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // configuration
    input wire logic [motion_wake_pkg::THLD_W-1:0] thresholdCode,
    // samples, one slice per axis
    input wire logic [AXES*ACCEL_W-1:0] accel,
    // result
    output logic motionLine
);

    typedef struct packed {
        logic line;  // registered motion line
    } det_state_t;

    det_state_t st;
    det_state_t next_st;
    logic [ACCEL_W-1:0] level;     // threshold in acceleration counts
    logic [AXES-1:0] over;         // per-axis exceed flags

    // map code to level: 0 means half g, else code minus one
    always_comb
    begin
        if (thresholdCode == motion_wake_pkg::THRESHOLD_RESERVED_CODE)
        begin
            level = ACCEL_W'(motion_wake_pkg::THLD_DEFAULT_LEVEL);
        end
        else
        begin
            level = ACCEL_W'(thresholdCode - motion_wake_pkg::THLD_ZERO_CODE);
        end
    end

    // one threshold checked against every axis magnitude
    genvar ax;
    generate
        for (ax = 0; ax < AXES; ax++)
        begin : g_axis
            logic [ACCEL_W-1:0] sample;
            logic [ACCEL_W-1:0] mag;
            assign sample = accel[ax*ACCEL_W +: ACCEL_W];
            assign mag = sample[ACCEL_W-1] ? ACCEL_W'(-sample) : sample;
            assign over[ax] = mag > level;
        end
    endgenerate

    // any axis beyond threshold raises the line
    always_comb
    begin
        next_st = st;
        next_st.line = |over;
    end

    // state register
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign motionLine = st.line;

endmodule // motion_threshold_detector

// >>> verif/motion_wake_controller_checker.sv
// Purpose: port-level checks on the motion wake controller
// Assumes: apb writes land at the edge where pready is sampled high
// Notes: tracks staged and applied mode from observed writes
`timescale 1ns/1ps
module motion_wake_controller_checker #(
    parameter int ALERT_WIDTH = 16
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // outputs
    input wire logic motionAlertOutput,
    input wire logic receiverAsleep,
    input wire logic irq
);
    logic wrEdge; // a write lands this edge
    logic restartWr; // power-cycle request lands
    logic sleepWr; // sleep request lands
    logic [1:0] stagedMode; // mode waiting for power cycle
    logic [1:0] appliedMode; // mode in force
    int alertRun; // cycles the alert has stood
    assign wrEdge = psel && penable && pready && pwrite;
    assign restartWr = wrEdge && paddr == motion_wake_pkg::RESTART_OFFSET && pwdata[0];
    assign sleepWr = wrEdge && paddr == motion_wake_pkg::POWER_REQ_OFFSET && pwdata[31]
        && pwdata[15:0] == 16'h0000;
    // shadow of the mode settings and alert length
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            stagedMode <= 2'h0;
            appliedMode <= 2'h0;
            alertRun <= 0;
        end
        else
        begin
            if (wrEdge && paddr == motion_wake_pkg::CONFIG_OFFSET)
                stagedMode <= pwdata[1:0];
            if (restartWr)
                appliedMode <= stagedMode;
            alertRun <= motionAlertOutput ? alertRun + 1 : 0;
        end
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("pready stood longer than one cycle");
    property p_ready_wait;
        $rose(penable) && psel |-> ##[1:2] pready;
    endproperty
    a_ready_wait: assert property (p_ready_wait)
        else $error("pready late after access phase");
    property p_err_ready;
        pslverr |-> pready;
    endproperty
    a_err_ready: assert property (p_err_ready)
        else $error("pslverr without pready");
    property p_reset_quiet;
        $fell(rst) |-> !motionAlertOutput && !receiverAsleep && !irq && !pready;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("outputs active after reset");
    property p_alert_width;
        $fell(motionAlertOutput) |-> alertRun >= ALERT_WIDTH;
    endproperty
    a_alert_width: assert property (p_alert_width)
        else $error("alert pulse too short");
    property p_alert_mode;
        $rose(motionAlertOutput) |-> appliedMode[0];
    endproperty
    a_alert_mode: assert property (p_alert_mode)
        else $error("alert in a mode without alert");
    property p_wake_mode;
        $fell(receiverAsleep) |-> appliedMode[1] || $past(restartWr) || $past(restartWr, 2);
    endproperty
    a_wake_mode: assert property (p_wake_mode)
        else $error("receiver woke in a mode without wake");
    property p_sleep_entry;
        $rose(receiverAsleep) |-> $past(sleepWr) || $past(sleepWr, 2);
    endproperty
    a_sleep_entry: assert property (p_sleep_entry)
        else $error("sleep without zero-duration request");
endmodule // motion_wake_controller_checker

bind motion_wake_controller motion_wake_controller_checker #(
    .ALERT_WIDTH(ALERT_WIDTH)
) i_motion_wake_controller_checker (
    .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .motionAlertOutput(motionAlertOutput), .receiverAsleep(receiverAsleep), .irq(irq)
);

// >>> verif/motion_sensor_model.sv
// Purpose: inertial sensor stand-in driving per-axis samples
// Assumes: one axis moves at a time, the others rest at zero
// Notes: samples change only right after a rising edge
`timescale 1ns/1ps
module motion_sensor_model #(
    parameter int AXES = 3,
    parameter int ACCEL_W = 16
) (
    // clock
    input wire logic clock,
    // command from the bench
    input wire logic [1:0] moveAxis,
    input wire logic [15:0] moveLevel,
    // samples toward the block
    output logic [AXES*ACCEL_W-1:0] accel
);
    // at rest before the first edge
    initial accel = '0;
    // chosen axis carries the level, the line runs in low power too
    always @(posedge clock)
    begin
        for (int i = 0; i < AXES; i++)
            accel[i*ACCEL_W+:ACCEL_W] <= (i == moveAxis) ? moveLevel : 16'h0000;
    end
endmodule // motion_sensor_model

// >>> verif/motion_wake_controller_tb_top.sv
// Purpose: self-checking bench for the motion wake controller
// Assumes: one wait state apb slave, alert two cycles after sample
// Notes: alert width shortened to 4 cycles
`timescale 1ns/1ps
module motion_wake_controller_tb_top;
    localparam int WID = 4; // short alert pulse
    localparam logic [7:0] A_CFG = motion_wake_pkg::CONFIG_OFFSET;
    localparam logic [7:0] A_APL = motion_wake_pkg::APPLIED_OFFSET;
    localparam logic [7:0] A_PWR = motion_wake_pkg::POWER_REQ_OFFSET;
    localparam logic [7:0] A_STT = motion_wake_pkg::STATE_OFFSET;
    localparam logic [7:0] A_STA = motion_wake_pkg::INT_STATUS_OFFSET;
    localparam logic [7:0] A_MSK = motion_wake_pkg::INT_MASK_OFFSET;
    localparam logic [7:0] A_RST = motion_wake_pkg::RESTART_OFFSET;
    // clock, reset, apb
    logic clock = 1'h0;
    logic rst = 1'h1;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    // sensor and outputs
    logic [47:0] accel;
    logic [1:0] moveAxis = 2'h0;
    logic [15:0] moveLevel = 16'h0;
    logic alert;
    logic asleep;
    logic irq;
    // bench state
    int failures = 0;
    int n_checks = 0;
    int cycles = 0;
    logic [31:0] rnd = 32'h00009e48;
    logic [31:0] q;
    logic e;
    logic seen;
    logic [15:0] lvl;
    logic [1:0] mi;
    motion_wake_controller #(.ALERT_WIDTH(WID)) i_motion_wake_controller (
        .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .accel(accel), .motionAlertOutput(alert),
        .receiverAsleep(asleep), .irq(irq));
    motion_sensor_model i_motion_sensor_model (
        .clock(clock), .moveAxis(moveAxis), .moveLevel(moveLevel), .accel(accel));
    // free-running clock
    always #4 clock = ~clock;
    // hang guard
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            failures++;
            stop_test();
        end
    end
    // xorshift step
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    // highest acceleration that stays quiet for a code
    function automatic logic [15:0] level(input logic [7:0] cd);
        return (cd == 8'h00) ? 16'h007f : {8'h00, cd - 8'h01};
    endfunction
    // one apb transfer, held until pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'h1;
        @(posedge clock);
        while (pready !== 1'h1 && n < 20)
        begin
            @(posedge clock);
            n++;
        end
        if (n == 20)
            failures++;
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    // compare and count
    task automatic check(input string nm, input logic [31:0] ex, input logic [31:0] got);
        n_checks++;
        if (got !== ex)
        begin
            failures++;
            $display("mismatch %s exp %h got %h", nm, ex, got);
        end
    endtask
    // stage settings then power-cycle
    task automatic cfg(input logic [1:0] md, input logic [7:0] cd);
        apb(1'h1, A_CFG, {16'h0, cd, 6'h0, md});
        apb(1'h1, A_RST, 32'h1);
    endtask
    // move one axis, watch the alert, then rest
    task automatic move(input logic [1:0] ax, input logic [15:0] lv);
        seen = 1'h0;
        moveAxis <= ax;
        moveLevel <= lv;
        repeat (6)
        begin
            @(posedge clock);
            seen = seen | (alert === 1'h1);
        end
        moveLevel <= 16'h0;
        repeat (WID + 6) @(posedge clock);
    endtask
    // verdict
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // main sequence
    initial
    begin
        repeat (2) @(posedge clock);
        rst <= 1'h0;
        apb(1'h0, A_APL, 32'h0);
        check("applied", 32'h0, q);
        apb(1'h0, 8'h1c, 32'h0);
        check("slverr", 32'h1, {31'h0, e});
        apb(1'h1, A_CFG, 32'h00002a01);
        apb(1'h0, A_CFG, 32'h0);
        check("config", 32'h00002a01, q);
        apb(1'h0, A_APL, 32'h0);
        check("staged", 32'h0, q);
        apb(1'h1, A_RST, 32'h1);
        apb(1'h0, A_APL, 32'h0);
        check("applied", 32'h00002a01, q);
        $display("test reset and staging done");
        // threshold edges, random axis and sign
        for (int k = 0; k < 6; k++)
        begin
            rnd = xs(rnd);
            lvl = level(k == 0 ? 8'h00 : k == 1 ? 8'h01 : k == 2 ? 8'hff : rnd[7:0] | 8'h01);
            cfg(2'h1, k == 0 ? 8'h00 : k == 1 ? 8'h01 : k == 2 ? 8'hff : rnd[7:0] | 8'h01);
            move(rnd[9:8] % 2'h3, rnd[10] ? -lvl : lvl);
            check("at level", 32'h0, {31'h0, seen});
            move(rnd[9:8] % 2'h3, rnd[10] ? -(lvl + 16'h1) : lvl + 16'h1);
            check("over level", 32'h1, {31'h0, seen});
        end
        $display("test threshold done");
        // every mode from sleep
        for (int m = 0; m < 4; m++)
        begin
            mi = 2'(m);
            cfg(mi, 8'h0b);
            apb(1'h1, A_MSK, 32'h2);
            apb(1'h1, A_PWR, 32'h80010000);
            repeat (2) @(posedge clock);
            check("asleep", 32'h1, {31'h0, asleep});
            apb(1'h0, A_STT, 32'h0);
            check("state", 32'h5, q);
            apb(1'h0, A_MSK, 32'h0);
            check("mask", 32'h2, q);
            move(2'h2, 16'h0032);
            check("alert", {31'h0, mi[0]}, {31'h0, seen});
            check("asleep", {31'h0, !mi[1]}, {31'h0, asleep});
            check("irq", {31'h0, mi[1]}, {31'h0, irq});
            apb(1'h1, A_STA, 32'h3);
            repeat (2) @(posedge clock);
            check("irq clear", 32'h0, {31'h0, irq});
        end
        $display("test modes done");
        // masked event, then unmasked
        cfg(2'h1, 8'h0b);
        apb(1'h1, A_MSK, 32'h0);
        move(2'h1, 16'hffce);
        check("irq masked", 32'h0, {31'h0, irq});
        apb(1'h1, A_MSK, 32'h1);
        repeat (2) @(posedge clock);
        check("irq unmasked", 32'h1, {31'h0, irq});
        // nonzero duration and disabled wake source
        cfg(2'h3, 8'h0b);
        apb(1'h1, A_PWR, 32'h80010005);
        repeat (2) @(posedge clock);
        check("no sleep", 32'h0, {31'h0, asleep});
        apb(1'h1, A_PWR, 32'h80000000);
        move(2'h0, 16'hffce);
        check("alert", 32'h1, {31'h0, seen});
        check("stays asleep", 32'h1, {31'h0, asleep});
        $display("test sleep request done");
        stop_test();
    end
endmodule // motion_wake_controller_tb_top
